// ===== rtl/ccp_pkg.sv
package ccp_pkg;

  // Register byte offsets
  localparam logic [11:0] OFS_SHUTDOWN_CTRL = 12'h000;
  localparam logic [11:0] OFS_MODE_CTRL = 12'h004;
  localparam logic [11:0] OFS_STATUS = 12'h008;

  // Values after reset
  localparam logic [31:0] RST_SHUTDOWN_CTRL = 32'h0100_0000;
  localparam logic [31:0] RST_MODE_CTRL = 32'h0000_0000;

  // Implemented bits, multi-output and single-output variants
  localparam logic [31:0] MASK2_MULTI = 32'hbfdf_d0ff;
  localparam logic [31:0] MASK2_SINGLE = 32'h81df_d0ff;
  localparam logic [31:0] MASK3_MULTI = 32'hf73f_003f;
  localparam logic [31:0] MASK3_SINGLE = 32'hf02c_0000;

  // Shutdown/gating control word fields
  localparam int POS_PIN_SYNC = 31;
  localparam int POS_STEER_LO = 24;
  localparam int POS_GATE_MODE = 22;
  localparam int POS_AUX_SEL = 19;
  localparam int POS_CAP_SEL = 16;
  localparam int POS_RESTART = 15;
  localparam int POS_SD_TIMING = 14;
  localparam int POS_SW_FORCE = 12;
  localparam logic [7:0] SRC_VALID = 8'hfb;

  // Output mode control word fields
  localparam int POS_HOLD = 31;
  localparam int POS_ONESHOT = 28;
  localparam int POS_DRIVE_MODE = 24;
  localparam int POS_POL_A = 21;
  localparam int POS_POL_B = 20;
  localparam int POS_SDSTATE_A = 18;
  localparam int POS_SDSTATE_B = 16;
  localparam int POS_DEAD_LO = 0;

  // Status word fields
  localparam int POS_CAP_DIS = 2;
  localparam int POS_SD_FLAG = 4;
  localparam int POS_GATE_ARM = 10;

  typedef enum logic [1:0] {
    GATE_LEVEL = 2'b00,
    GATE_RISE = 2'b01,
    GATE_FALL = 2'b10
  } gate_mode_t;

  typedef enum logic [2:0] {
    DRV_STEER = 3'b000,
    DRV_PUSH_PULL = 3'b001,
    DRV_HALF_BRIDGE = 3'b010,
    DRV_BDC_REV = 3'b100,
    DRV_BDC_FWD = 3'b101,
    DRV_SCAN = 3'b110
  } drive_mode_t;

endpackage : ccp_pkg

// ===== rtl/ccp_output_shutdown_control.sv
// Overview of operation
// - Pin-enable sync defers steering updates to rollover
// - Each enable hands its pin to module
// - Single-output variant keeps only pin A enable
// - Gate mode: level, one-shot rise, one-shot fall
// - Aux select: off, rollover, mode, events
// - Capture source: pin, comparators, logic cells
// - Restart enable auto-clears shutdown flag next period
// - Gate timing defers shutdown to rollover
// - Software force acts as a fired source
// - Source enables pick shutdown triggers, all but bit 2 of eight
// - Hold outputs undriven until triggered
// - One-shot trigger lasts n+1 timer periods
// - Drive mode selects multi-output pattern
// - Polarity for A, C, E pins
// - Polarity for B, D, F pins, multi only
// - Shutdown state for A, C, E pins
// - Unimplemented bits ignore writes, read zero
// - Shutdown state for B, D, F pins, multi only
// - Dead time between complementary outputs
// - Shutdown flag reads one during shutdown
// - Capture disable flag blocks capture events
//
// Added by the designer: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none

module ccp_output_shutdown_control #(
  parameter bit MULTI_OUTPUT = 1'b1
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Time base and compare engine
  input wire logic tbRollover,
  input wire logic timerTick,
  input wire logic pwmIn,
  input wire logic timerMode,
  input wire logic modeSignal,
  input wire logic captureEvent,
  input wire logic compareEvent,
  input wire logic triggeredOperationEnable,
  input wire logic timerTriggered,
  input wire logic oneShotTrigger,
  // Shutdown sources, bit 7 fault pin B down to comparator 1
  input wire logic [7:0] shutdownSources,
  // Capture inputs
  input wire logic capturePin,
  input wire logic captureCmp1,
  input wire logic captureCmp2,
  input wire logic captureCell1,
  input wire logic captureCell2,
  // Capture and event outputs
  output logic captureOut,
  output logic auxEventOut,
  output logic oneShotActive,
  // Output pins A..F
  output logic [5:0] pinOut,
  output logic [5:0] pinOe_n,
  output logic [5:0] pinOwned
);
  import ccp_pkg::*;

  localparam logic [31:0] MASK2 = MULTI_OUTPUT ? MASK2_MULTI : MASK2_SINGLE;
  localparam logic [31:0] MASK3 = MULTI_OUTPUT ? MASK3_MULTI : MASK3_SINGLE;

  typedef struct packed {
    logic [31:0] ctrl2;
    logic [31:0] ctrl3;
    logic [5:0] enEff;
    logic sdActive;
    logic capDis;
    logic gateArm;
    logic gatePrev;
    logic [2:0] one_shot_extend;
    logic osOn;
    logic [5:0] dtCnt;
    logic pwmPrev;
    logic [2:0] scanIdx;
    logic pushSel;
    logic [5:0] pinOut;
    logic [5:0] pinOeN;
    logic [5:0] pinOwn;
    logic capOut;
    logic aux_event_select;
    logic [31:0] rdata;
    logic ready;
    logic err;
    logic live;
  } state_t;

  state_t st;
  state_t next_st;

  logic wrEn;
  logic mapped;
  logic sdRequest;
  logic sdFire;
  logic swClear;
  logic holdPins;
  logic deadEdge;
  logic capSel;
  logic [5:0] act;
  logic [5:0] pol;
  logic [5:0] hiz;
  logic [5:0] sdLevel;
  logic [5:0] steerReq;
  gate_mode_t gateMode;
  drive_mode_t driveMode;
  logic [1:0] pssA;
  logic [1:0] pssB;

  assign mapped = (paddr == OFS_SHUTDOWN_CTRL) || (paddr == OFS_MODE_CTRL)
                  || (paddr == OFS_STATUS);
  assign wrEn = psel && penable && st.ready && pwrite && mapped;
  assign steerReq = st.ctrl2[POS_STEER_LO +: 6];
  assign gateMode = gate_mode_t'(st.ctrl2[POS_GATE_MODE +: 2]);
  assign driveMode = drive_mode_t'(st.ctrl3[POS_DRIVE_MODE +: 3]);
  assign pssA = st.ctrl3[POS_SDSTATE_A +: 2];
  assign pssB = st.ctrl3[POS_SDSTATE_B +: 2];

  // Source OR, with the software force as one more source
  assign sdRequest = (|(shutdownSources & st.ctrl2[7:0] & SRC_VALID))
                     || st.ctrl2[POS_SW_FORCE];
  assign sdFire = sdRequest && (!st.ctrl2[POS_SD_TIMING] || tbRollover);
  assign swClear = wrEn && (paddr == OFS_STATUS) && !pwdata[POS_SD_FLAG];
  assign holdPins = st.ctrl3[POS_HOLD] && triggeredOperationEnable
                    && !timerTriggered;
  // Blank on the edge itself, or both halves would switch together
  assign deadEdge = (pwmIn != st.pwmPrev)
                    && (st.ctrl3[POS_DEAD_LO +: 6] != 6'h00);

  always_comb begin
    capSel = 1'b0;
    unique case (st.ctrl2[POS_CAP_SEL +: 3])
      3'b000: capSel = capturePin;
      3'b001: capSel = captureCmp1;
      3'b010: capSel = captureCmp2;
      3'b100: capSel = captureCell1;
      3'b101: capSel = captureCell2;
      default: capSel = 1'b0;
    endcase
  end

  // Logical activity per pin before polarity
  always_comb begin
    act = 6'h00;
    unique case (driveMode)
      DRV_STEER: act = {6{pwmIn}};
      DRV_PUSH_PULL: act = {3{pwmIn && st.pushSel, pwmIn && !st.pushSel}};
      // Dead time holds both halves inactive after every edge
      DRV_HALF_BRIDGE: act = (deadEdge || st.dtCnt != 6'h00) ? 6'h00 :
                             {3{!pwmIn, pwmIn}};
      DRV_BDC_REV: act = {4'h0, pwmIn, 1'b0} | 6'h04;
      DRV_BDC_FWD: act = {2'h0, pwmIn, 3'h0} | 6'h01;
      DRV_SCAN: act = pwmIn ? (6'h01 << st.scanIdx) : 6'h00;
      default: act = 6'h00;
    endcase
  end

  always_comb begin
    pol = {3{st.ctrl3[POS_POL_B], st.ctrl3[POS_POL_A]}};
    hiz = {3{!pssB[1], !pssA[1]}};
    sdLevel = {3{pssB[0], pssA[0]}} ^ pol;
  end

  always_comb begin
    next_st = st;
    next_st.live = 1'b1;
    // APB: setup phase prepares the answer, access phase completes
    next_st.ready = psel && !penable;
    next_st.err = psel && !penable && !mapped;
    if (psel && !penable) begin
      unique case (paddr)
        OFS_SHUTDOWN_CTRL: next_st.rdata = st.ctrl2;
        OFS_MODE_CTRL: next_st.rdata = st.ctrl3;
        OFS_STATUS: next_st.rdata = {27'h0, st.sdActive, 1'b0,
                                     st.capDis, 2'h0};
        default: next_st.rdata = 32'h0000_0000;
      endcase
    end
    if (wrEn && paddr == OFS_SHUTDOWN_CTRL) begin
      next_st.ctrl2 = pwdata & MASK2;
    end
    if (wrEn && paddr == OFS_MODE_CTRL) begin
      next_st.ctrl3 = pwdata & MASK3;
    end

    // Steering enables
    if (!st.ctrl2[POS_PIN_SYNC] || tbRollover) begin
      next_st.enEff = steerReq;
    end

    // Shutdown flag: a new shutdown beats any clear in the same cycle
    if (swClear) begin
      next_st.sdActive = 1'b0;
    end
    if (st.ctrl2[POS_RESTART] && !sdRequest && tbRollover) begin
      next_st.sdActive = 1'b0;
    end
    if (sdFire) begin
      next_st.sdActive = 1'b1;
    end

    // Capture gating uses the same sources as shutdown
    next_st.gatePrev = sdRequest;
    if (wrEn && paddr == OFS_STATUS && pwdata[POS_GATE_ARM]) begin
      next_st.gateArm = 1'b1;
    end
    unique case (gateMode)
      GATE_LEVEL: next_st.capDis = !sdRequest;
      GATE_RISE: begin
        if (st.gateArm && sdRequest && !st.gatePrev) begin
          next_st.capDis = 1'b0;
          next_st.gateArm = 1'b0;
        end
      end
      GATE_FALL: begin
        if (st.gateArm && !sdRequest && st.gatePrev) begin
          next_st.capDis = 1'b1;
          next_st.gateArm = 1'b0;
        end
      end
      default: next_st.capDis = st.capDis;
    endcase
    next_st.capOut = capSel && !st.capDis;

    unique case (st.ctrl2[POS_AUX_SEL +: 2])
      2'b00: next_st.aux_event_select = 1'b0;
      2'b01: next_st.aux_event_select = tbRollover;
      2'b10: next_st.aux_event_select = modeSignal;
      default: next_st.aux_event_select = !timerMode && (captureEvent || compareEvent);
    endcase

    // One-shot stretch counted in timer periods
    if (oneShotTrigger) begin
      next_st.osOn = 1'b1;
      next_st.one_shot_extend = st.ctrl3[POS_ONESHOT +: 3];
    end else if (st.osOn && timerTick) begin
      if (st.one_shot_extend == 3'h0) begin
        next_st.osOn = 1'b0;
      end else begin
        next_st.one_shot_extend = st.one_shot_extend - 3'h1;
      end
    end

    // Pattern sequencing per period
    next_st.pwmPrev = pwmIn;
    if (deadEdge) begin
      next_st.dtCnt = st.ctrl3[POS_DEAD_LO +: 6] - 6'h01;
    end else if (st.dtCnt != 6'h00) begin
      next_st.dtCnt = st.dtCnt - 6'h01;
    end
    if (tbRollover) begin
      next_st.pushSel = !st.pushSel;
      next_st.scanIdx = (st.scanIdx == 3'h5) ? 3'h0 : st.scanIdx + 3'h1;
    end

    // Pin stage: polarity, shutdown state, ownership
    next_st.pinOwn = st.enEff;
    next_st.pinOut = st.sdActive ? sdLevel : (act ^ pol);
    next_st.pinOeN = ~(st.enEff & {6{!holdPins}}
                       & ~({6{st.sdActive}} & hiz));
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st <= '0;
      st.ctrl2 <= RST_SHUTDOWN_CTRL;
      st.ctrl3 <= RST_MODE_CTRL;
      st.pinOeN <= 6'h3f;
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.rdata;
  assign pready = st.ready;
  assign pslverr = st.err;
  assign captureOut = st.capOut;
  assign auxEventOut = st.aux_event_select;
  assign oneShotActive = st.osOn;
  assign pinOut = st.pinOut;
  assign pinOe_n = st.pinOeN;
  assign pinOwned = st.pinOwn;

  default clocking cb @(posedge mclk);
  endclocking
  // The release edge still registers reset values, so skip it as well
  default disable iff (rst || !st.live);

  sequence sdRelease;
    st.sdActive && st.ctrl2[POS_RESTART] && !sdRequest ##0 tbRollover;
  endsequence

  sequence sdWaitGated;
    !st.sdActive && st.ctrl2[POS_SD_TIMING] && !tbRollover;
  endsequence

  a_sd_immediate: assert property (
    sdRequest && !st.ctrl2[POS_SD_TIMING] |=> st.sdActive)
    else $error("immediate shutdown not taken");

  a_sd_gated_wait: assert property (
    sdWaitGated |=> !st.sdActive)
    else $error("gated shutdown before rollover");

  a_restart_clear: assert property (
    sdRelease |=> !st.sdActive)
    else $error("auto restart did not clear flag");

  a_no_autoclear: assert property (
    st.sdActive && !st.ctrl2[POS_RESTART] && !swClear |=> st.sdActive)
    else $error("shutdown flag cleared without software");

  a_enable_sync: assert property (
    st.ctrl2[POS_PIN_SYNC] && !tbRollover |=> $stable(st.enEff))
    else $error("steering changed outside rollover");

  a_enable_now: assert property (
    !st.ctrl2[POS_PIN_SYNC] |=> st.enEff == $past(steerReq))
    else $error("steering update delayed");

  a_hold_undriven: assert property (
    holdPins |=> pinOe_n == 6'h3f)
    else $error("pins driven before trigger");

  a_gate_level: assert property (
    gateMode == GATE_LEVEL |=> st.capDis == !$past(sdRequest))
    else $error("level gating mismatch");

  a_cap_blocked: assert property (
    st.capDis |=> !captureOut)
    else $error("capture passed while disabled");

  a_oneshot_end: assert property (
    st.osOn && st.one_shot_extend == 3'h0 && timerTick && !oneShotTrigger
    |=> !oneShotActive ##1 !oneShotActive || oneShotTrigger)
    else $error("one-shot ran past its count");

  a_unimpl_zero: assert property (
    ((st.ctrl2 & ~MASK2) == 32'h0) && ((st.ctrl3 & ~MASK3) == 32'h0))
    else $error("unimplemented bit set");

  a_sd_hiz: assert property (
    st.sdActive && !pssA[1] && st.enEff[0] |=> pinOe_n[0])
    else $error("pin A driven in high-impedance shutdown");

endmodule : ccp_output_shutdown_control

`default_nettype wire

// ===== bench/power_stage.sv
`timescale 1ns/1ps
`default_nettype none

module power_stage (
  // Module side
  input wire logic [5:0] drive,
  input wire logic [5:0] driveEn_n,
  // Load side
  output logic [5:0] level
);
  // Gate inputs carry pull-downs, so a released pin reads low
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      level[i] = driveEn_n[i] ? 1'h0 : drive[i];
    end
  end
endmodule : power_stage

`default_nettype wire

// ===== bench/tb_ccp_output_shutdown_control.sv
`timescale 1ns/1ps
`default_nettype none

module tb_ccp_output_shutdown_control;
  import ccp_pkg::*;
  logic mclk = '0, rst = '1;
  logic psel = '0, penable = '0, pwrite = '0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, lastErr;
  logic tbRollover = '0, timerTick = '0, pwmIn = '0, timerMode = '0;
  logic modeSignal = '0, captureEvent = '0, compareEvent = '0;
  logic triggered_operation_enable = '0, timerTriggered = '0, oneShotTrigger = '0;
  logic [7:0] srcs = '0;
  logic [4:0] capIn = '0;
  logic captureOut, auxEventOut, oneShotActive;
  logic [5:0] pinOut, pinOe_n, pinOwned, pinLevel;
  int fails = 0, cmp_count = 0;

  ccp_output_shutdown_control u_ccp_output_shutdown_control (
    .mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .tbRollover(tbRollover),
    .timerTick(timerTick), .pwmIn(pwmIn), .timerMode(timerMode),
    .modeSignal(modeSignal), .captureEvent(captureEvent),
    .compareEvent(compareEvent), .triggeredOperationEnable(triggered_operation_enable),
    .timerTriggered(timerTriggered), .oneShotTrigger(oneShotTrigger),
    .shutdownSources(srcs), .capturePin(capIn[0]),
    .captureCmp1(capIn[1]), .captureCmp2(capIn[2]),
    .captureCell1(capIn[3]), .captureCell2(capIn[4]),
    .captureOut(captureOut), .auxEventOut(auxEventOut),
    .oneShotActive(oneShotActive), .pinOut(pinOut),
    .pinOe_n(pinOe_n), .pinOwned(pinOwned)
  );

  power_stage u_power_stage (
    .drive(pinOut), .driveEn_n(pinOe_n), .level(pinLevel)
  );

  initial begin
    forever #12.5 mclk = ~mclk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc

  // Holds the request until pready is sampled high, releases, idles once
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= '1;
    penable <= '0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= '1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'h1);
    rd = prdata;
    lastErr = pslverr;
    psel <= '0;
    penable <= '0;
    @(posedge mclk);
  endtask : apb

  task automatic ctl(input logic [31:0] d);
    apb('1, OFS_SHUTDOWN_CTRL, d);
  endtask : ctl

  task automatic mode(input logic [31:0] d);
    apb('1, OFS_MODE_CTRL, d);
  endtask : mode

  task automatic stat();
    apb('0, OFS_STATUS, '0);
  endtask : stat

  task automatic roll();
    tbRollover <= '1;
    @(posedge mclk);
    tbRollover <= '0;
    cyc(2);
  endtask : roll

  task automatic t_regs();
    cyc(3);
    chk("owned", pinOwned, 6'h01);
    apb('0, OFS_SHUTDOWN_CTRL, '0);
    chk("ctl2", rd, 32'h0100_0000);
    apb('0, OFS_MODE_CTRL, '0);
    chk("ctl3", rd, 32'h0000_0000);
    apb('0, 12'h00c, '0);
    chk("slverr", lastErr, 1'h1);
    chk("unmapped", rd, 32'h0);
    ctl('1);
    apb('0, OFS_SHUTDOWN_CTRL, '0);
    chk("ctl2 mask", rd, 32'hbfdf_d0ff);
    mode('1);
    apb('0, OFS_MODE_CTRL, '0);
    chk("ctl3 mask", rd, 32'hf73f_003f);
    ctl(32'h0100_0000);
    mode('0);
    apb('1, OFS_STATUS, '0);
  endtask : t_regs

  task automatic t_steer();
    ctl(32'h3f00_0000);
    cyc(2);
    chk("steer now", pinOwned, 6'h3f);
    ctl(32'h8500_0000);
    cyc(3);
    chk("steer held", pinOwned, 6'h3f);
    roll();
    chk("steer roll", pinOwned, 6'h05);
  endtask : t_steer

  // Every enable bit alone, with all other sources firing
  task automatic t_sources();
    for (int b = 0; b < 8; b++) begin
      ctl(32'h0100_0000 | (32'h1 << b));
      srcs <= ~(8'h1 << b);
      cyc(3);
      stat();
      chk("masked src", rd[4], 1'h0);
      srcs <= 8'h1 << b;
      cyc(3);
      stat();
      chk("src flag", rd[4], b != 2);
      srcs <= '0;
      apb('1, OFS_STATUS, '0);
    end
  endtask : t_sources

  task automatic t_sdstate();
    ctl(32'h0300_0001);
    mode(32'h000e_0000);
    srcs <= 8'h01;
    cyc(4);
    chk("state a", {pinOe_n[0], pinOut[0]}, 2'h1);
    chk("state b", {pinOe_n[1], pinOut[1]}, 2'h0);
    mode(32'h0000_0000);
    cyc(3);
    chk("hiz", {pinOe_n[1:0], pinLevel[1:0]}, 4'hc);
    srcs <= '0;
    cyc(4);
    stat();
    chk("no restart", rd[4], 1'h1);
    apb('1, OFS_STATUS, '0);
    cyc(3);
    stat();
    chk("sw clear", rd[4], 1'h0);
    chk("resumed", pinOe_n[1:0], 2'h0);
  endtask : t_sdstate

  task automatic t_gated();
    ctl(32'h0100_5000);
    cyc(4);
    stat();
    chk("gated wait", rd[4], 1'h0);
    roll();
    stat();
    chk("forced", rd[4], 1'h1);
    ctl(32'h0100_c000);
    cyc(2);
    stat();
    chk("restart wait", rd[4], 1'h1);
    roll();
    stat();
    chk("restarted", rd[4], 1'h0);
  endtask : t_gated

  task automatic t_pol();
    ctl(32'h0300_0000);
    mode(32'h0030_0000);
    pwmIn <= '1;
    cyc(3);
    chk("pol low", pinOut[1:0], 2'h0);
    mode(32'h8000_0000);
    triggered_operation_enable <= '1;
    cyc(3);
    chk("pol high", pinOut[1:0], 2'h3);
    chk("hold", pinOe_n[1:0], 2'h3);
    timerTriggered <= '1;
    cyc(3);
    chk("triggered", pinOe_n[1:0], 2'h0);
    pwmIn <= '0;
  endtask : t_pol

  task automatic t_oneshot();
    mode(32'h3000_0000);
    oneShotTrigger <= '1;
    @(posedge mclk);
    oneShotTrigger <= '0;
    cyc(2);
    chk("shot start", oneShotActive, 1'h1);
    for (int i = 1; i <= 4; i++) begin
      timerTick <= '1;
      @(posedge mclk);
      timerTick <= '0;
      cyc(2);
      chk("shot len", oneShotActive, i < 4);
    end
  endtask : t_oneshot

  task automatic t_capture();
    logic [2:0] code [5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5};
    for (int k = 0; k < 5; k++) begin
      ctl(32'h0100_1000 | (32'(code[k]) << 16));
      capIn <= ~(5'h1 << k);
      cyc(3);
      chk("cap off", captureOut, 1'h0);
      capIn <= 5'h1 << k;
      cyc(3);
      chk("cap on", captureOut, 1'h1);
    end
    ctl(32'h0100_0000);
    capIn <= '1;
    cyc(3);
    stat();
    chk("level off", {rd[2], captureOut}, 2'h2);
    ctl(32'h0140_0000);
    apb('1, OFS_STATUS, 32'h400);
    ctl(32'h0140_1000);
    cyc(3);
    chk("rise on", captureOut, 1'h1);
    ctl(32'h0180_1000);
    apb('1, OFS_STATUS, 32'h400);
    ctl(32'h0180_0000);
    cyc(3);
    chk("fall off", captureOut, 1'h0);
    capIn <= '0;
  endtask : t_capture

  task automatic t_aux();
    ctl(32'h0108_0000);
    tbRollover <= '1;
    @(posedge mclk);
    tbRollover <= '0;
    @(posedge mclk);
    chk("aux roll", auxEventOut, 1'h1);
    cyc(1);
    chk("aux idle", auxEventOut, 1'h0);
    ctl(32'h0110_0000);
    modeSignal <= '1;
    cyc(3);
    chk("aux mode", auxEventOut, 1'h1);
    modeSignal <= '0;
    ctl(32'h0118_0000);
    compareEvent <= '1;
    cyc(3);
    chk("aux event", auxEventOut, 1'h1);
    compareEvent <= '0;
    captureEvent <= '1;
    timerMode <= '1;
    cyc(3);
    chk("aux timer", auxEventOut, 1'h0);
    timerMode <= '0;
    ctl(32'h0100_0000);
    cyc(3);
    chk("aux off", auxEventOut, 1'h0);
    captureEvent <= '0;
  endtask : t_aux

  // Drive patterns; a dead time of 2 blanks both halves for two cycles
  task automatic t_drive();
    logic [1:0] pp;
    logic [5:0] s;
    ctl(32'h0300_0000);
    apb('1, OFS_STATUS, '0);
    mode(32'h0200_0002);
    cyc(2);
    chk("bridge", pinOut[1:0], 2'h2);
    pwmIn <= '1;
    cyc(2);
    chk("dead edge", pinOut[1:0], 2'h0);
    cyc(1);
    chk("dead", pinOut[1:0], 2'h0);
    cyc(1);
    chk("dead end", pinOut[1:0], 2'h1);
    mode(32'h0500_0000);
    cyc(2);
    chk("brush fwd", pinOut, 6'h09);
    mode(32'h0400_0000);
    cyc(2);
    chk("brush rev", pinOut, 6'h06);
    mode(32'h0100_0000);
    cyc(2);
    pp = pinOut[1:0];
    chk("push one", pp[0] ^ pp[1], 1'h1);
    roll();
    chk("push swap", pinOut[1:0], {pp[0], pp[1]});
    mode(32'h0600_0000);
    cyc(2);
    s = pinOut;
    chk("scan one", $countones(s), 1);
    roll();
    chk("scan next", pinOut, {s[4:0], s[5]});
    pwmIn <= '0;
  endtask : t_drive

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : report_and_stop

  // The whole sequence needs well under 3000 cycles
  initial begin
    #(25 * 20000);
    fails++;
    report_and_stop();
  end

  initial begin
    cyc(6);
    rst <= '0;
    t_regs();
    t_steer();
    t_sources();
    t_sdstate();
    t_gated();
    t_pol();
    t_oneshot();
    t_capture();
    t_aux();
    t_drive();
    report_and_stop();
  end
endmodule : tb_ccp_output_shutdown_control

`default_nettype wire
